// ### hw/rtcc_defs.svh
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// register indices; byte address is four times the index
`define RTCC_IDX_CONTROL_MAIN 4'h0
`define RTCC_IDX_SYNC_BUSY 4'h1
`define RTCC_IDX_IRQ_ENABLE 4'h2
`define RTCC_IDX_IRQ_FLAGS 4'h3
`define RTCC_IDX_BYTE_LATCH 4'h4
`define RTCC_IDX_HALT_BEHAV 4'h5
`define RTCC_IDX_RESERVED6 4'h6
`define RTCC_IDX_SOURCE_SEL 4'h7
`define RTCC_IDX_COUNT_LO 4'h8
`define RTCC_IDX_COUNT_HI 4'h9
`define RTCC_IDX_LIMIT_LO 4'hA
`define RTCC_IDX_LIMIT_HI 4'hB
`define RTCC_IDX_MATCH_LO 4'hC
`define RTCC_IDX_MATCH_HI 4'hD

// reset values
`define RTCC_RST_BYTE 8'h00
`define RTCC_RST_COUNT 16'h0000
`define RTCC_RST_LIMIT 16'hFFFF
`define RTCC_RST_MATCH 16'h0000

// field positions
`define RTCC_BIT_ENABLE 0
`define RTCC_BIT_STBY 7
`define RTCC_BIT_MATCH 1
`define RTCC_BIT_WRAP 0
`define RTCC_BIT_DEBUG_KEEP_RUNNING 0

// sync slots inside the busy register
`define RTCC_SYNC_CTRL 0
`define RTCC_SYNC_COUNT 1
`define RTCC_SYNC_LIMIT 2
`define RTCC_SYNC_MATCH 3

// slow-clock cycles of write synchronisation latency
`define RTCC_SYNC_CYCLES 2'd2

// axi responses
`define RTCC_RESP_OKAY 2'b00
`define RTCC_RESP_SLVERR 2'b10

`endif

// ### hw/rtcc_pkg.sv
package rtcc_pkg;

	// main control byte layout
	typedef struct packed {
		logic standby_run;
		logic [3:0] prescale;
		logic [1:0] unused;
		logic counter_enable;
	} rtcc_ctrl_t;

	// counter clock source codes
	typedef enum logic [1:0] {
		RTCC_SRC_INTERNAL_FAST_SLOW_SOURCE = 2'b00,
		RTCC_SRC_INTERNAL_KILOHERTZ_SOURCE = 2'b01,
		RTCC_SRC_RSVD = 2'b10,
		RTCC_SRC_PIN = 2'b11
	} rtcc_src_t;

	// event outputs travel together
	typedef struct packed {
		logic match;
		logic wrap;
	} rtcc_evt_t;

endpackage

// ### hw/rtcc_core.sv
// The AXI4-Lite register port is this design's own decision.
`include "rtcc_defs.svh"

// Contract
// - standby_run keeps counting during standby sleep
// - prescale field divides by two to power
// - control write applies after two slow cycles
// - bit zero enables the counter
// - busy bits for match and limit writes
// - busy bits for count and control writes
// - enable bit one gates match interrupt
// - enable bit zero gates wrap interrupt
// - match flag set on equality, w1c
// - wrap flag set on wrap, w1c
// - shared byte latch, read write, resets zero
// - debug halt stops counter unless debug_keep_running
// - source select picks counter clock source
// - count split low high, two-cycle sync
// - wrap limit resets all ones, synced
// - event pulses last one slow period
// - irq asserted while flag and enable set
// - match value read write, resets zero
module rtcc_core
	import rtcc_pkg::*;
(
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	// axi4-lite write address
	input wire logic [5:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	// axi4-lite write data
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	// axi4-lite write response
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// axi4-lite read
	input wire logic [5:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	// slow sources, synchronous one-cycle ticks and pin level
	input wire logic I_TICK_INTERNAL_FAST_SLOW_SOURCE,
	input wire logic I_TICK_INTERNAL_KILOHERTZ_SOURCE,
	input wire logic I_PIN_CLOCK,
	// system state
	input wire logic I_STANDBY,
	input wire logic I_DEBUG_HALT,
	// results
	output logic O_IRQ,
	output logic O_WRAP_EVENT,
	output logic O_MATCH_EVENT
);

	// bus-side register copies
	rtcc_ctrl_t ctrl_q; // control as software sees it
	logic [1:0] irq_en_q; // interrupt enables
	logic [1:0] flags_q; // sticky flags
	logic [7:0] latch_q; // shared byte latch
	logic dbg_run_q; // debug_keep_running
	rtcc_src_t src_q; // source_select
	logic [15:0] limit_q; // wrap_limit as written
	logic [15:0] match_q; // match_value as written
	logic [15:0] count_wr_q; // count waiting to be applied
	// values in force in the counting logic
	rtcc_ctrl_t ctrl_eff_q;
	logic [15:0] limit_eff_q;
	logic [15:0] match_eff_q;
	logic [15:0] count_q; // live count
	logic [14:0] pre_q; // prescaler
	logic [1:0] sync_q [4]; // per-register sync countdown
	logic [3:0] sync_done; // countdown just reached zero
	logic [3:0] sync_start; // a write starts a countdown
	logic pin_q; // previous pin level for edge detect
	logic slow_tick; // one selected source cycle
	logic running;
	logic div_tick; // prescaled count tick
	logic [15:0] count_nxt;
	logic wrap_hit;
	logic match_hit;
	// bus plumbing
	logic aw_have_q, w_have_q;
	logic [5:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_lane0_q;
	logic do_wr;
	logic [3:0] wr_idx;
	logic wr_ok;
	logic rd_fire;
	logic [3:0] rd_idx;
	logic [1:0] flags_d;
	logic [7:0] rd_byte;
	logic rd_ok;

	// source choice; pin edge counts as one cycle, reserved stands still
	always_comb begin
		case (src_q)
			RTCC_SRC_INTERNAL_FAST_SLOW_SOURCE: slow_tick = I_TICK_INTERNAL_FAST_SLOW_SOURCE;
			RTCC_SRC_INTERNAL_KILOHERTZ_SOURCE: slow_tick = I_TICK_INTERNAL_KILOHERTZ_SOURCE;
			RTCC_SRC_PIN: slow_tick = I_PIN_CLOCK & ~pin_q;
			default: slow_tick = 1'b0;
		endcase
	end

	// pin history for edge detect
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= I_PIN_CLOCK;
		end
	end

	// gating: enable, standby, debug halt
	assign running = ctrl_eff_q.counter_enable
		& ~(I_STANDBY & ~ctrl_eff_q.standby_run)
		& ~(I_DEBUG_HALT & ~dbg_run_q);
	// divide by 2^prescale: terminal when low bits are all ones
	assign div_tick = running & slow_tick
		& (((pre_q | ~((15'h0001 << ctrl_eff_q.prescale) - 15'h0001))
		== 15'h7FFF));
	assign wrap_hit = div_tick & (count_q == limit_eff_q);
	assign count_nxt = wrap_hit ? 16'h0000 : count_q + 16'h0001;
	assign match_hit = div_tick & (count_nxt == match_eff_q);

	// prescaler restarts at each count tick
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pre_q <= 15'h0000;
		end else if (div_tick || !running) begin
			pre_q <= 15'h0000;
		end else if (slow_tick) begin
			pre_q <= pre_q + 15'h0001;
		end
	end

	// write sync countdowns, counted in selected slow cycles
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < 4; i++) begin
				sync_q[i] <= 2'd0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (sync_start[i]) begin
					sync_q[i] <= `RTCC_SYNC_CYCLES;
				end else if (slow_tick && sync_q[i] != 2'd0) begin
					sync_q[i] <= sync_q[i] - 2'd1;
				end
			end
		end
	end
	// a fresh write restarts the wait, so done is masked by start
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			sync_done[i] = slow_tick & (sync_q[i] == 2'd1) & ~sync_start[i];
		end
	end

	// settings take effect only when their sync finishes
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_eff_q <= rtcc_ctrl_t'(`RTCC_RST_BYTE);
			limit_eff_q <= `RTCC_RST_LIMIT;
			match_eff_q <= `RTCC_RST_MATCH;
		end else begin
			if (sync_done[`RTCC_SYNC_CTRL]) begin
				ctrl_eff_q <= ctrl_q;
			end
			if (sync_done[`RTCC_SYNC_LIMIT]) begin
				limit_eff_q <= limit_q;
			end
			if (sync_done[`RTCC_SYNC_MATCH]) begin
				match_eff_q <= match_q;
			end
		end
	end

	// live count; a synced write overrides the increment
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			count_q <= `RTCC_RST_COUNT;
		end else if (sync_done[`RTCC_SYNC_COUNT]) begin
			count_q <= count_wr_q;
		end else if (div_tick) begin
			count_q <= count_nxt;
		end
	end

	// events held for one slow cycle, refreshed every slow cycle
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_WRAP_EVENT <= 1'b0;
			O_MATCH_EVENT <= 1'b0;
		end else if (slow_tick) begin
			O_WRAP_EVENT <= wrap_hit;
			O_MATCH_EVENT <= match_hit;
		end
	end

	// axi write: address and data captured in either order
	assign do_wr = aw_have_q & w_have_q & ~O_BVALID;
	assign wr_idx = aw_addr_q[5:2];
	assign wr_ok = (aw_addr_q[1:0] == 2'b00) && (wr_idx <= `RTCC_IDX_MATCH_HI);
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 6'h00;
			w_data_q <= 8'h00;
			w_lane0_q <= 1'b0;
			O_AWREADY <= 1'b1;
			O_WREADY <= 1'b1;
			O_BVALID <= 1'b0;
			O_BRESP <= `RTCC_RESP_OKAY;
		end else begin
			if (O_AWREADY && I_AWVALID) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= I_AWADDR;
				O_AWREADY <= 1'b0;
			end
			if (O_WREADY && I_WVALID) begin
				w_have_q <= 1'b1;
				w_data_q <= I_WDATA[7:0];
				w_lane0_q <= I_WSTRB[0];
				O_WREADY <= 1'b0;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= wr_ok ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
			end
			// readies return only after the response is taken
			if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
				O_AWREADY <= 1'b1;
				O_WREADY <= 1'b1;
			end
		end
	end

	// one-hot start of a sync countdown
	always_comb begin
		sync_start = 4'h0;
		if (do_wr && wr_ok && w_lane0_q) begin
			case (wr_idx)
				`RTCC_IDX_CONTROL_MAIN: sync_start[`RTCC_SYNC_CTRL] = 1'b1;
				`RTCC_IDX_COUNT_HI: sync_start[`RTCC_SYNC_COUNT] = 1'b1;
				`RTCC_IDX_LIMIT_HI: sync_start[`RTCC_SYNC_LIMIT] = 1'b1;
				`RTCC_IDX_MATCH_HI: sync_start[`RTCC_SYNC_MATCH] = 1'b1;
				default: sync_start = 4'h0;
			endcase
		end
	end

	// flag next value: hardware set beats software clear
	always_comb begin
		flags_d = flags_q;
		if (do_wr && wr_ok && w_lane0_q
			&& wr_idx == `RTCC_IDX_IRQ_FLAGS) begin
			flags_d = flags_q & ~w_data_q[1:0];
		end
		flags_d[`RTCC_BIT_WRAP] = flags_d[`RTCC_BIT_WRAP] | wrap_hit;
		flags_d[`RTCC_BIT_MATCH] = flags_d[`RTCC_BIT_MATCH] | match_hit;
	end

	// flags and the interrupt line
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			flags_q <= 2'b00;
			O_IRQ <= 1'b0;
		end else begin
			flags_q <= flags_d;
			O_IRQ <= |(flags_d & irq_en_q);
		end
	end

	// register writes; the low byte of a pair only fills the latch
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_q <= rtcc_ctrl_t'(`RTCC_RST_BYTE);
			irq_en_q <= 2'b00;
			latch_q <= `RTCC_RST_BYTE;
			dbg_run_q <= 1'b0;
			src_q <= RTCC_SRC_INTERNAL_FAST_SLOW_SOURCE;
			limit_q <= `RTCC_RST_LIMIT;
			match_q <= `RTCC_RST_MATCH;
			count_wr_q <= `RTCC_RST_COUNT;
		end else if (do_wr && wr_ok && w_lane0_q) begin
			case (wr_idx)
				`RTCC_IDX_CONTROL_MAIN: begin
					ctrl_q <= rtcc_ctrl_t'(w_data_q & 8'hF9);
				end
				`RTCC_IDX_IRQ_ENABLE: irq_en_q <= w_data_q[1:0];
				`RTCC_IDX_BYTE_LATCH: latch_q <= w_data_q;
				`RTCC_IDX_HALT_BEHAV: dbg_run_q <= w_data_q[`RTCC_BIT_DEBUG_KEEP_RUNNING];
				`RTCC_IDX_SOURCE_SEL: src_q <= rtcc_src_t'(w_data_q[1:0]);
				`RTCC_IDX_COUNT_LO, `RTCC_IDX_LIMIT_LO,
				`RTCC_IDX_MATCH_LO: begin
					latch_q <= w_data_q;
				end
				`RTCC_IDX_COUNT_HI: count_wr_q <= {w_data_q, latch_q};
				`RTCC_IDX_LIMIT_HI: limit_q <= {w_data_q, latch_q};
				`RTCC_IDX_MATCH_HI: match_q <= {w_data_q, latch_q};
				default: ctrl_q <= ctrl_q;
			endcase
		end else if (rd_fire && rd_ok) begin
			// low-byte read parks the high byte for a coherent pair
			case (rd_idx)
				`RTCC_IDX_COUNT_LO: latch_q <= count_q[15:8];
				`RTCC_IDX_LIMIT_LO: latch_q <= limit_q[15:8];
				`RTCC_IDX_MATCH_LO: latch_q <= match_q[15:8];
				default: latch_q <= latch_q;
			endcase
		end
	end

	// read decode; high bytes of pairs return the latch
	assign rd_fire = O_ARREADY & I_ARVALID;
	assign rd_idx = I_ARADDR[5:2];
	assign rd_ok = (I_ARADDR[1:0] == 2'b00) && (rd_idx <= `RTCC_IDX_MATCH_HI);
	always_comb begin
		case (rd_idx)
			`RTCC_IDX_CONTROL_MAIN: rd_byte = ctrl_q;
			`RTCC_IDX_SYNC_BUSY: begin
				rd_byte = 8'h00;
				for (int i = 0; i < 4; i++) begin
					rd_byte[i] = (sync_q[i] != 2'd0);
				end
			end
			`RTCC_IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_en_q};
			`RTCC_IDX_IRQ_FLAGS: rd_byte = {6'h00, flags_q};
			`RTCC_IDX_BYTE_LATCH: rd_byte = latch_q;
			`RTCC_IDX_HALT_BEHAV: rd_byte = {7'h00, dbg_run_q};
			`RTCC_IDX_SOURCE_SEL: rd_byte = {6'h00, src_q};
			`RTCC_IDX_COUNT_LO: rd_byte = count_q[7:0];
			`RTCC_IDX_LIMIT_LO: rd_byte = limit_q[7:0];
			`RTCC_IDX_MATCH_LO: rd_byte = match_q[7:0];
			`RTCC_IDX_COUNT_HI, `RTCC_IDX_LIMIT_HI,
			`RTCC_IDX_MATCH_HI: rd_byte = latch_q;
			default: rd_byte = 8'h00;
		endcase
	end

	// axi read channel, one outstanding read
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= `RTCC_RESP_OKAY;
		end else if (rd_fire) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
			O_RRESP <= rd_ok ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID <= 1'b0;
			O_ARREADY <= 1'b1;
		end
	end

endmodule // rtcc_core

// ### bench/rtcc_core_checker.sv
module rtcc_core_checker (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	// write side of the bus
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	// read side of the bus
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	// request line
	input wire logic O_IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	// single domain, so one clock and one disable for all
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);

	// response exactly two edges after the joint handshake
	AST_B_TIMING: assert property (I_AWVALID && O_AWREADY && I_WVALID
		&& O_WREADY |=> ##1 O_BVALID) else $error("write answer late");
	// read data one edge after the address is taken
	AST_R_TIMING: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read answer late");
	// answers stand until taken
	AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID
		&& $stable(O_BRESP)) else $error("write answer dropped");
	AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID
		&& $stable(O_RDATA)) else $error("read answer dropped");
	// no new request accepted while an answer is pending
	AST_B_READY: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write ready during answer");
	AST_R_READY: assert property (O_RVALID |-> !O_ARREADY)
		else $error("read ready during answer");
	AST_W_REOPEN: assert property (O_BVALID && I_BREADY |=> O_AWREADY
		&& O_WREADY) else $error("write ready not back");
	// registers are one byte wide
	AST_R_UPPER: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
		else $error("upper read bits set");
	// request only drops through a register write
	AST_IRQ_FALL: assert property ($fell(O_IRQ) |-> O_BVALID
		|| $past(O_BVALID)) else $error("request dropped by itself");
endmodule // rtcc_core_checker

bind rtcc_core rtcc_core_checker i_chk (.I_MCLK, .I_RST_N, .I_AWVALID,
	.O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY,
	.I_ARVALID, .O_ARREADY, .O_RDATA, .O_RVALID, .I_RREADY, .O_IRQ);

// ### bench/tb.sv
`include "rtcc_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// bench-driven inputs
	logic clk, rst_n, awv, wv, bready, arv, rready, t32, t1k, pin, stby, halt;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdat;
	logic [1:0] resp;
	logic [7:0] c; // count snapshot
	logic seen_m, seen_w; // event pulses observed
	// design outputs
	wire logic awready, wready, bvalid, arready, rvalid, irq, wrap_ev, match_ev;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int n_mismatch, total_checks, cyc, i;

	rtcc_core i_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr),
		.I_AWVALID(awv), .O_AWREADY(awready), .I_WDATA(wdata),
		.I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
		.I_ARVALID(arv), .O_ARREADY(arready), .O_RDATA(rdata),
		.O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_TICK_INTERNAL_FAST_SLOW_SOURCE(t32), .I_TICK_INTERNAL_KILOHERTZ_SOURCE(t1k), .I_PIN_CLOCK(pin),
		.I_STANDBY(stby), .I_DEBUG_HALT(halt), .O_IRQ(irq),
		.O_WRAP_EVENT(wrap_ev), .O_MATCH_EVENT(match_ev));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic final_report;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask

	// event catcher and hang guard
	always @(posedge clk) begin
		cyc++;
		// catchers start clear while reset is held
		if (rst_n !== 1'b1) begin
			seen_m <= 1'b0;
			seen_w <= 1'b0;
		end
		if (match_ev === 1'b1) seen_m <= 1'b1;
		if (wrap_ev === 1'b1) seen_w <= 1'b1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report;
		end
	end

	// bus write; address and data go out together, each dropped when taken
	task automatic wr(input logic [3:0] ix, input logic [7:0] d);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		awaddr <= {ix, 2'b00};
		wdata <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) a = 1'b1;
			if (wready) w = 1'b1;
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
		end while (!(a && w));
		while (bvalid !== 1'b1) @(posedge clk);
		resp = bresp;
		bready <= 1'b0;
		// one idle edge: next call never re-raises bready on this edge
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] ix);
		araddr <= {ix, 2'b00};
		arv <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
		// one idle edge: next call never re-raises rready on this edge
		@(posedge clk);
	endtask

	// slow ticks on the source of code s; code 2 pulses every source
	task automatic tk(input int n, input int s);
		repeat (n) begin
			t32 <= (s == 0 || s == 2);
			t1k <= (s == 1 || s == 2);
			pin <= (s >= 2);
			@(posedge clk);
			{t32, t1k, pin} <= 3'b000;
			repeat (3) @(posedge clk);
		end
	endtask

	// count must move by k steps over n ticks; limit 3 keeps it in 0..3
	task automatic adv(input int s, input int n, input logic [7:0] k);
		rd(4'h8);
		c = rdat[7:0];
		tk(n, s);
		rd(4'h8);
		chk("count", rdat, 32'((c + k) & 8'h03));
	endtask

	initial begin
		{rst_n, awv, wv, bready, arv, rready, t32, t1k, pin} = 9'h000;
		{stby, halt} = 2'h0;
		{awaddr, araddr, wdata} = 44'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// reset image of the whole map
		for (i = 0; i < 14; i++) begin
			rd(4'(i));
			chk("reset", rdat, (i == 10 || i == 11) ? 32'hFF : 32'h0);
		end
		rd(4'hE);
		chk("rd unmapped", 32'(resp), 32'(`RTCC_RESP_SLVERR));
		wr(4'hF, 8'h11);
		chk("wr unmapped", 32'(resp), 32'(`RTCC_RESP_SLVERR));
		wr(4'h4, 8'h5A);
		rd(4'h4);
		chk("latch", rdat, 32'h5A);
		// limit 3 then match 2, each busy until two ticks pass
		wr(4'hA, 8'h03);
		wr(4'hB, 8'h00);
		rd(4'h1);
		chk("limit busy", rdat, 32'h04);
		rd(4'hA);
		rd(4'h4);
		chk("latch hi", rdat, 32'h00);
		tk(2, 0);
		rd(4'h1);
		chk("limit idle", rdat, 32'h00);
		wr(4'hC, 8'h02);
		wr(4'hD, 8'h00);
		rd(4'h1);
		chk("match busy", rdat, 32'h08);
		tk(2, 0);
		wr(4'h2, 8'h03);
		rd(4'h2);
		chk("enables", rdat, 32'h03);
		// enable: busy lasts exactly two ticks
		wr(4'h0, 8'h01);
		tk(1, 0);
		rd(4'h1);
		chk("ctrl busy", rdat, 32'h01);
		tk(1, 0);
		rd(4'h1);
		chk("ctrl idle", rdat, 32'h00);
		rd(4'h8);
		tk(3 - int'(rdat[1:0]), 0);
		rd(4'h8);
		chk("count", rdat, 32'h03);
		rd(4'h3);
		chk("flags", rdat, 32'h02);
		chk("irq", 32'(irq), 32'h1);
		chk("match event", 32'(seen_m), 32'h1);
		tk(1, 0);
		rd(4'h8);
		chk("wrapped", rdat, 32'h00);
		rd(4'h3);
		chk("flags", rdat, 32'h03);
		chk("wrap event", 32'(seen_w), 32'h1);
		// clearing and masking
		wr(4'h3, 8'h01);
		rd(4'h3);
		chk("w1c", rdat, 32'h02);
		wr(4'h3, 8'h00);
		rd(4'h3);
		chk("w0", rdat, 32'h02);
		wr(4'h2, 8'h01);
		chk("masked", 32'(irq), 32'h0);
		wr(4'h2, 8'h03);
		wr(4'h3, 8'h02);
		chk("cleared", 32'(irq), 32'h0);
		// divide by two, then gating
		wr(4'h0, 8'h09);
		tk(2, 0);
		adv(0, 4, 8'h02);
		halt <= 1'b1;
		adv(0, 4, 8'h00);
		wr(4'h5, 8'h01);
		adv(0, 4, 8'h02);
		halt <= 1'b0;
		stby <= 1'b1;
		adv(0, 4, 8'h00);
		wr(4'h0, 8'h89);
		tk(2, 0);
		adv(0, 4, 8'h02);
		rd(4'h0);
		chk("control", rdat, 32'h89);
		stby <= 1'b0;
		for (i = 1; i < 4; i++) begin
			wr(4'h7, 8'(i));
			adv(i, 4, (i == 2) ? 8'h00 : 8'h02);
		end
		wr(4'h7, 8'h00);
		wr(4'h0, 8'h08);
		tk(2, 0);
		adv(0, 4, 8'h00);
		// count load through the latch
		wr(4'h8, 8'h02);
		wr(4'h9, 8'h00);
		rd(4'h1);
		chk("count busy", rdat, 32'h02);
		tk(2, 0);
		rd(4'h1);
		chk("count idle", rdat, 32'h00);
		rd(4'h8);
		chk("count load", rdat, 32'h02);
		final_report;
	end
endmodule // tb
